// ### src/hbu_byte_cmp.sv
/*
  hbu_byte_cmp: one byte comparator with a don't-care enable.
  assumes: purely combinational use inside the breakpoint unit.
*/
`timescale 1ns/10ps
module hbu_byte_cmp
  import hbu_pkg::*;
(
  input wire logic [7:0] ref_i,
  input wire logic [7:0] bus_i,
  input wire logic use_i,
  output logic hit_o
);

  // an unused byte always matches, which gives range compare
  assign hit_o = !use_i || (ref_i == bus_i);

endmodule

// ### src/hbu_pkg.sv
/*
  hbu_pkg: register offsets, field positions, reset values and mode codes
  of the hardware breakpoint unit.
  assumes: an 8-bit register port with byte offsets as printed.
*/
package hbu_pkg;

  // register offsets (8-bit register port, byte addresses)
  localparam logic [7:0] HBU_ADDR_CTL0 = 8'h20;
  localparam logic [7:0] HBU_ADDR_CTL1 = 8'h21;
  localparam logic [7:0] HBU_ADDR_AH = 8'h22;
  localparam logic [7:0] HBU_ADDR_AL = 8'h23;
  localparam logic [7:0] HBU_ADDR_DH = 8'h24;
  localparam logic [7:0] HBU_ADDR_DL = 8'h25;

  // control 0 fields
  localparam int HBU_C0_MODE_HI = 7;
  localparam int HBU_C0_MODE_LO = 6;
  localparam int HBU_C0_PROG = 5;
  localparam int HBU_C0_RANGE1 = 3;
  localparam int HBU_C0_RANGE0 = 2;
  localparam logic [7:0] HBU_C0_MASK = 8'hEC;

  // control 1 fields
  localparam int HBU_C1_DBE = 6;
  localparam int HBU_C1_MBH = 5;
  localparam int HBU_C1_MBL = 4;
  localparam int HBU_C1_RWE1 = 3;
  localparam int HBU_C1_RW1 = 2;
  localparam int HBU_C1_RWE0 = 1;
  localparam int HBU_C1_RW0 = 0;
  localparam logic [7:0] HBU_C1_MASK = 8'h7F;

  localparam logic [7:0] HBU_RESET_VAL = 8'h00;

  typedef enum logic [1:0] {
    HBU_MODE_OFF = 2'b00,
    HBU_MODE_SWI_DUAL = 2'b01,
    HBU_MODE_BDM_FULL = 2'b10,
    HBU_MODE_BDM_DUAL = 2'b11
  } hbu_mode_t;

endpackage

// ### src/hbu_rw_qual.sv
/*
  hbu_rw_qual: read/write cycle qualifier for one breakpoint.
  assumes: rw_i high on read cycles, low on write cycles.
*/
`timescale 1ns/10ps
module hbu_rw_qual
  import hbu_pkg::*;
(
  input wire logic enable_i,
  input wire logic value_i,
  input wire logic rw_i,
  output logic ok_o
);

  // value clear selects writes, set selects reads
  assign ok_o = !enable_i || (rw_i == value_i);

endmodule

// ### src/hbu_top.sv
/*
  hbu_top: hardware breakpoint unit. holds the control and compare
  registers, watches the cpu address, data and read/write lines and
  raises one software interrupt or debug entry request on a match.
  assumes: cpu bus signals and debug controller signals are on clk_i;
  the cpu handles tagging for program-only breaks.
*/
// The address-and-strobe port was decided locally.
// Functional notes
// RULE1: two-bit mode field picks off, swi dual, bdm full, bdm dual.
// RULE2: no breakpoint while background debug is active.
// RULE3: only swi dual mode requests a software interrupt; program only.
// RULE4: swi dual mode ignores all read/write compare bits.
// RULE5: in dual modes data enable bit enables the second breakpoint.
// RULE6: compare size select has no effect in dual modes.
// RULE7: bdm modes break only while debug enable from controller is set.
// RULE8: bdm dual breakpoints use program-only, range and rw bits.
// RULE9: program-only clear breaks at boundary; set tags executed opcodes.
// RULE10: program-only bit has no meaning in swi dual mode.
// RULE11: breakpoint 0 range: clear compares high byte, set full address.
// RULE12: breakpoint 1 range in dual modes adds low data compare byte.
// RULE13: data enable clear keeps data compare registers out of matches.
// RULE14: full mode high mask set drops data bits 15:8 from match.
// RULE15: full mode low mask set drops data bits 7:0 from match.
// RULE16: breakpoint 1 rw enable qualifies only dual second breakpoint.
// RULE17: breakpoint 1 rw value clear matches writes, set matches reads.
// RULE18: breakpoint 0 rw enable adds read/write to its match.
// RULE19: control 0 holds mode, program-only, range bits; rest read zero.
// RULE20: control 1 bit 7 reads zero; bits 6..0 are compare controls.
// RULE21: software arms bdm breakpoints only with debug enable set.
// RULE22: breakpoint 0 rw value clear matches writes, set reads.
// RULE23: high address register vs address high byte, low vs low byte.
// RULE24: a qualified match drives one swi or debug entry request.
`timescale 1ns/10ps
module hbu_top
  import hbu_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [15:0] cpu_addr_i,
  input wire logic [15:0] cpu_data_i,
  input wire logic cpu_rw_i,
  input wire logic cpu_valid_i,
  input wire logic cpu_fetch_i,
  input wire logic bdm_active_i,
  input wire logic bdm_enable_i,
  output logic swi_req_o,
  output logic bdm_req_o,
  output logic tag_o
);

  logic [7:0] ctl0;
  logic [7:0] ctl1;
  logic [7:0] addr_hi;
  logic [7:0] addr_lo;
  logic [7:0] data_hi;
  logic [7:0] data_lo;
  logic [7:0] next_rdata;

  function automatic logic sel(input logic [7:0] a, input logic [7:0] o);
    sel = (a == o);
  endfunction

  // register writes
  wire wr_c0 = reg_write_i && sel(reg_addr_i, HBU_ADDR_CTL0);
  wire wr_c1 = reg_write_i && sel(reg_addr_i, HBU_ADDR_CTL1);
  wire wr_ah = reg_write_i && sel(reg_addr_i, HBU_ADDR_AH);
  wire wr_al = reg_write_i && sel(reg_addr_i, HBU_ADDR_AL);
  wire wr_dh = reg_write_i && sel(reg_addr_i, HBU_ADDR_DH);
  wire wr_dl = reg_write_i && sel(reg_addr_i, HBU_ADDR_DL);

  // control fields
  hbu_mode_t mode;
  assign mode = hbu_mode_t'({ctl0[HBU_C0_MODE_HI], ctl0[HBU_C0_MODE_LO]});
  wire prog_only = ctl0[HBU_C0_PROG];
  wire range1 = ctl0[HBU_C0_RANGE1];
  wire range0 = ctl0[HBU_C0_RANGE0];
  wire data_en = ctl1[HBU_C1_DBE];
  wire mask_hi = ctl1[HBU_C1_MBH];
  wire mask_lo = ctl1[HBU_C1_MBL];
  wire rwe1 = ctl1[HBU_C1_RWE1];
  wire rw1 = ctl1[HBU_C1_RW1];
  wire rwe0 = ctl1[HBU_C1_RWE0];
  wire rw0 = ctl1[HBU_C1_RW0];

  // RULE19 control 0 storage
  // RULE20 control 1 storage
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctl0 <= HBU_RESET_VAL;
      ctl1 <= HBU_RESET_VAL;
      addr_hi <= HBU_RESET_VAL;
      addr_lo <= HBU_RESET_VAL;
      data_hi <= HBU_RESET_VAL;
      data_lo <= HBU_RESET_VAL;
    end else begin
      if (wr_c0) ctl0 <= reg_wdata_i & HBU_C0_MASK;
      if (wr_c1) ctl1 <= reg_wdata_i & HBU_C1_MASK;
      if (wr_ah) addr_hi <= reg_wdata_i;
      if (wr_al) addr_lo <= reg_wdata_i;
      if (wr_dh) data_hi <= reg_wdata_i;
      if (wr_dl) data_lo <= reg_wdata_i;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = HBU_RESET_VAL;
    case (reg_addr_i)
      HBU_ADDR_CTL0: next_rdata = ctl0;
      HBU_ADDR_CTL1: next_rdata = ctl1;
      HBU_ADDR_AH: next_rdata = addr_hi;
      HBU_ADDR_AL: next_rdata = addr_lo;
      HBU_ADDR_DH: next_rdata = data_hi;
      HBU_ADDR_DL: next_rdata = data_lo;
      default: next_rdata = HBU_RESET_VAL;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= HBU_RESET_VAL;
    end else if (reg_read_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  // RULE1 mode decode
  wire is_swi = (mode == HBU_MODE_SWI_DUAL);
  wire is_full = (mode == HBU_MODE_BDM_FULL);
  wire is_dual_bdm = (mode == HBU_MODE_BDM_DUAL);
  // RULE6 size select is not even an input: dual matching ignores it
  wire is_dual = is_swi || is_dual_bdm;

  // RULE23 breakpoint 0 address bytes
  // RULE11 low byte only with range 0 set
  logic bp0_hi;
  logic bp0_lo;
  hbu_byte_cmp u_bp0_hi (
    .ref_i(addr_hi),
    .bus_i(cpu_addr_i[15:8]),
    .use_i(1'b1),
    .hit_o(bp0_hi)
  );
  hbu_byte_cmp u_bp0_lo (
    .ref_i(addr_lo),
    .bus_i(cpu_addr_i[7:0]),
    .use_i(range0),
    .hit_o(bp0_lo)
  );

  // data compare registers face the address bus in dual modes
  // and the data bus in full mode
  wire [15:0] cmp_bus = is_dual ? cpu_addr_i : cpu_data_i;
  // RULE12 second range bit adds low byte in dual modes
  // RULE14 high mask in full mode
  // RULE15 low mask in full mode
  wire use_dhi = is_dual || !mask_hi;
  wire use_dlo = is_dual ? range1 : !mask_lo;
  logic d_hi;
  logic d_lo;
  hbu_byte_cmp u_d_hi (
    .ref_i(data_hi),
    .bus_i(cmp_bus[15:8]),
    .use_i(use_dhi),
    .hit_o(d_hi)
  );
  hbu_byte_cmp u_d_lo (
    .ref_i(data_lo),
    .bus_i(cmp_bus[7:0]),
    .use_i(use_dlo),
    .hit_o(d_lo)
  );

  // RULE22 breakpoint 0 cycle type
  // RULE18 rw line added to breakpoint 0
  // RULE4 swi mode drops rw qualification
  logic rw0_ok;
  hbu_rw_qual u_rw0 (
    .enable_i(rwe0 && !is_swi && !prog_only),
    .value_i(rw0),
    .rw_i(cpu_rw_i),
    .ok_o(rw0_ok)
  );
  // RULE16 breakpoint 1 rw only for dual second breakpoint
  // RULE17 breakpoint 1 cycle type
  logic rw1_ok;
  hbu_rw_qual u_rw1 (
    .enable_i(rwe1 && is_dual_bdm && !prog_only),
    .value_i(rw1),
    .rw_i(cpu_rw_i),
    .ok_o(rw1_ok)
  );

  // RULE13 data registers used only with data enable
  // RULE5 data enable gates the second address breakpoint
  wire bp1_hit = is_dual && data_en && d_hi && d_lo && rw1_ok;
  wire full_data_ok = !data_en || (d_hi && d_lo);
  wire bp0_hit = bp0_hi && bp0_lo && rw0_ok && (is_dual || full_data_ok);

  // RULE8 bdm dual qualification
  // RULE3 swi mode is program fetch only
  // RULE10 program bit moot in swi mode
  // RULE9 program-only restricts to fetches, tagged
  wire prog_path = is_swi || prog_only;
  wire cycle_ok = cpu_valid_i && (!prog_path || cpu_fetch_i);
  wire any_hit = (bp0_hit || bp1_hit) && cycle_ok;

  // RULE2 suppressed during active debug
  // RULE7 bdm modes need debug enable
  // RULE21 no hardware interlock beyond this enable term
  wire swi_hit = any_hit && is_swi && !bdm_active_i;
  wire bdm_hit = any_hit && (is_full || is_dual_bdm) && !bdm_active_i
                 && bdm_enable_i;

  // RULE24 one registered request per qualified match
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      swi_req_o <= 1'b0;
      bdm_req_o <= 1'b0;
      tag_o <= 1'b0;
    end else begin
      swi_req_o <= swi_hit;
      bdm_req_o <= bdm_hit;
      tag_o <= (swi_hit || bdm_hit) && prog_path;
    end
  end

endmodule

// ### test/hbu_cpu_model.sv
/*
  hbu_cpu_model: cpu core and debug controller as seen by the unit.
  assumes: one bus cycle at a time, driven just after clk_i rises.
*/
`timescale 1ns/10ps
module hbu_cpu_model (
  input wire logic clk_i,
  output logic [15:0] addr_o,
  output logic [15:0] data_o,
  output logic rw_o,
  output logic valid_o,
  output logic fetch_o,
  output logic dbg_active_o,
  output logic dbg_enable_o
);
  initial begin
    {addr_o, data_o, rw_o, valid_o, fetch_o, dbg_active_o} = '0;
    dbg_enable_o = 1'b1;
  end
  // debug controller lines change just after an edge, like the bus
  task automatic set_dbg(input logic act, en);
    @(posedge clk_i);
    dbg_active_o <= act;
    dbg_enable_o <= en;
  endtask
  // released lines flip so a stale value cannot fake a match
  task automatic cycle(input logic [15:0] a, d, input logic r, f);
    @(posedge clk_i);
    {addr_o, data_o, rw_o, fetch_o, valid_o} <= {a, d, r, f, 1'b1};
    @(posedge clk_i);
    {addr_o, data_o, rw_o, fetch_o, valid_o} <= {~a, ~d, ~r, ~f, 1'b0};
  endtask
endmodule

// ### test/hbu_props.sv
/*
  hbu_props: port-level checks of the breakpoint unit.
  assumes: bound to hbu_top; shadows the two control registers.
*/
`timescale 1ns/10ps
module hbu_props
  import hbu_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic cpu_valid_i,
  input wire logic cpu_fetch_i,
  input wire logic bdm_active_i,
  input wire logic bdm_enable_i,
  input wire logic swi_req_o,
  input wire logic bdm_req_o,
  input wire logic tag_o
);
  logic [7:0] c0;
  logic [7:0] c1;
  wire wr0 = reg_write_i && reg_addr_i == HBU_ADDR_CTL0;
  wire wr1 = reg_write_i && reg_addr_i == HBU_ADDR_CTL1;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      c0 <= HBU_RESET_VAL;
      c1 <= HBU_RESET_VAL;
    end else begin
      if (wr0) c0 <= reg_wdata_i & HBU_C0_MASK;
      if (wr1) c1 <= reg_wdata_i & HBU_C1_MASK;
    end
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  property p_quiet;
    bdm_active_i |=> !swi_req_o && !bdm_req_o;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("request while debug active");
  property p_one;
    swi_req_o || bdm_req_o |-> $past(cpu_valid_i) && !(swi_req_o && bdm_req_o);
  endproperty
  a_one: assert property (p_one)
    else $error("request without bus cycle");
  property p_swi;
    swi_req_o |-> $past(c0[7:6]) == HBU_MODE_SWI_DUAL && $past(cpu_fetch_i) && tag_o;
  endproperty
  a_swi: assert property (p_swi)
    else $error("bad software interrupt");
  property p_en;
    bdm_req_o |-> $past(bdm_enable_i) && $past(c0[7]);
  endproperty
  a_en: assert property (p_en)
    else $error("debug entry not enabled");
  property p_off;
    c0[7:6] == HBU_MODE_OFF |=> !swi_req_o && !bdm_req_o;
  endproperty
  a_off: assert property (p_off)
    else $error("request with unit off");
  property p_rd0;
    reg_read_i && reg_addr_i == HBU_ADDR_CTL0 |=> reg_rdata_o == $past(c0);
  endproperty
  a_rd0: assert property (p_rd0)
    else $error("control 0 read wrong");
  property p_rd1;
    reg_read_i && reg_addr_i == HBU_ADDR_CTL1 |=> reg_rdata_o == $past(c1);
  endproperty
  a_rd1: assert property (p_rd1)
    else $error("control 1 read wrong");
  property p_prog;
    bdm_req_o && $past(c0[HBU_C0_PROG]) |-> $past(cpu_fetch_i) && tag_o;
  endproperty
  a_prog: assert property (p_prog)
    else $error("program break on data cycle");
  c_swi: cover property (swi_req_o);
  c_dbg: cover property (bdm_req_o && tag_o);
  c_act: cover property (bdm_active_i && cpu_valid_i);
endmodule
bind hbu_top hbu_props i_hbu_props (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
  .reg_rdata_o(reg_rdata_o), .cpu_valid_i(cpu_valid_i),
  .cpu_fetch_i(cpu_fetch_i), .bdm_active_i(bdm_active_i),
  .bdm_enable_i(bdm_enable_i), .swi_req_o(swi_req_o),
  .bdm_req_o(bdm_req_o), .tag_o(tag_o));

// ### test/hbu_top_tb.sv
/*
  hbu_top_tb: table of bus cycles, then register, gating and reset tests.
  assumes: compare registers hold 12 34 56 78 until the final reset.
*/
`timescale 1ns/10ps
module hbu_top_tb
  import hbu_pkg::*;
;
  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] addr;
    logic [15:0] data;
    logic [1:0] rwf;
    logic [2:0] exp;
  } hbu_row_t;
  logic clk, reset_n, reg_write, reg_read, rw, valid, fetch, act, en;
  logic swi, dbg, tag;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [15:0] addr, data;
  int error_cnt = 0;
  int num_checks = 0;
  hbu_row_t rows [15] = '{
    '{16'h0000,16'h1234,16'h0000,2'b01,3'b000},
    '{16'h4000,16'h12ff,16'h0000,2'b01,3'b101},
    '{16'h4400,16'h1234,16'h0000,2'b01,3'b101},
    '{16'h6003,16'h1234,16'h0000,2'b01,3'b101},
    '{16'h4000,16'h5678,16'h0000,2'b01,3'b000},
    '{16'h4840,16'h5678,16'h0000,2'b01,3'b101},
    '{16'h4840,16'h56aa,16'h0000,2'b01,3'b000},
    '{16'hc002,16'h1200,16'h0000,2'b10,3'b000},
    '{16'hc04c,16'h5600,16'h0000,2'b10,3'b010},
    '{16'he000,16'h1200,16'h0000,2'b01,3'b011},
    '{16'h8060,16'h12aa,16'h0078,2'b10,3'b010},
    '{16'h8050,16'h12aa,16'h5600,2'b10,3'b010},
    '{16'h8000,16'h12aa,16'h0000,2'b10,3'b010},
    '{16'h800c,16'h1200,16'h0000,2'b00,3'b010},
    '{16'hc002,16'h1200,16'h0000,2'b00,3'b010}};
  hbu_cpu_model i_hbu_cpu_model (.clk_i(clk), .addr_o(addr), .data_o(data),
    .rw_o(rw), .valid_o(valid), .fetch_o(fetch), .dbg_active_o(act),
    .dbg_enable_o(en));
  hbu_top i_hbu_top (.clk_i(clk), .reset_n_i(reset_n), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_write_i(reg_write), .reg_read_i(reg_read),
    .reg_rdata_o(reg_rdata), .cpu_addr_i(addr), .cpu_data_i(data),
    .cpu_rw_i(rw), .cpu_valid_i(valid), .cpu_fetch_i(fetch),
    .bdm_active_i(act), .bdm_enable_i(en), .swi_req_o(swi),
    .bdm_req_o(dbg), .tag_o(tag));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic tally(input string what, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, e);
    @(posedge clk);
    {reg_addr, reg_read} <= {a, 1'b1};
    @(posedge clk);
    reg_read <= 1'b0;
    #1 tally("rdata", e, reg_rdata);
  endtask
  // requests stand one cycle, so look right after the answering edge
  task automatic bus_chk(input logic [15:0] a, d, input logic [1:0] rf,
                         input logic [2:0] e);
    i_hbu_cpu_model.cycle(a, d, rf[1], rf[0]);
    #1 tally("req", {5'h00, e}, {5'h00, swi, dbg, tag});
  endtask
  initial begin
    #20000;
    error_cnt++;
    summarize();
  end
  initial begin
    {reset_n, reg_write, reg_read, reg_addr, reg_wdata} = '0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    wr(HBU_ADDR_AH, 8'h12);
    wr(HBU_ADDR_AL, 8'h34);
    wr(HBU_ADDR_DH, 8'h56);
    wr(HBU_ADDR_DL, 8'h78);
    foreach (rows[i]) begin
      wr(HBU_ADDR_CTL0, rows[i].cfg[15:8]);
      wr(HBU_ADDR_CTL1, rows[i].cfg[7:0]);
      bus_chk(rows[i].addr, rows[i].data, rows[i].rwf, rows[i].exp);
    end
    rd_chk(HBU_ADDR_AH, 8'h12);
    rd_chk(HBU_ADDR_AL, 8'h34);
    rd_chk(HBU_ADDR_DH, 8'h56);
    rd_chk(HBU_ADDR_DL, 8'h78);
    wr(HBU_ADDR_CTL0, 8'hff);
    rd_chk(HBU_ADDR_CTL0, HBU_C0_MASK);
    wr(HBU_ADDR_CTL1, 8'hff);
    rd_chk(HBU_ADDR_CTL1, HBU_C1_MASK);
    wr(8'h26, 8'hff);
    rd_chk(8'h26, 8'h00);
    wr(HBU_ADDR_CTL0, 8'h40);
    wr(HBU_ADDR_CTL1, 8'h00);
    i_hbu_cpu_model.set_dbg(1'b1, 1'b1);
    bus_chk(16'h1234, 16'h0000, 2'b01, 3'b000);
    i_hbu_cpu_model.set_dbg(1'b0, 1'b0);
    bus_chk(16'h1234, 16'h0000, 2'b01, 3'b101);
    wr(HBU_ADDR_CTL0, 8'hc0);
    bus_chk(16'h1234, 16'h0000, 2'b01, 3'b000);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rd_chk(HBU_ADDR_CTL0, HBU_RESET_VAL);
    rd_chk(HBU_ADDR_CTL1, HBU_RESET_VAL);
    bus_chk(16'h1234, 16'h0000, 2'b01, 3'b000);
    summarize();
  end
endmodule
